// file: pkg/dapf_pkg.sv
/*
  Constants for the denial-of-service packet filter: register map,
  reset values, signature indices and header-field limits.
  Assumes a single pclk domain and an APB master for software access.
*/
`default_nettype none
package dapf_pkg;
  localparam int NUM_SIG = 8;
  localparam int SIG_W = 3;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 3;
  localparam int CNT_W = 32;
  localparam logic [SIG_W-1:0] SIG_SELF_IP = 3'h0;
  localparam logic [SIG_W-1:0] SIG_EQ_PORT = 3'h1;
  localparam logic [SIG_W-1:0] SIG_NULL = 3'h2;
  localparam logic [SIG_W-1:0] SIG_ALLFLG = 3'h3;
  localparam logic [SIG_W-1:0] SIG_SYNFIN = 3'h4;
  localparam logic [SIG_W-1:0] SIG_LOWSYN = 3'h5;
  localparam logic [SIG_W-1:0] SIG_OVPING = 3'h6;
  localparam logic [SIG_W-1:0] SIG_TINY = 3'h7;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SIG_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DROPS = 8'h10;
  localparam int CTRL_GLB = 0;
  localparam int CTRL_TRAP = 1;
  localparam int CTRL_ALL = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [NUM_SIG-1:0] SIG_EN_RST = 8'h00;
  localparam logic [NUM_SIG-1:0] MASK_RST = 8'h00;
  localparam int FLG_FIN = 0;
  localparam int FLG_SYN = 1;
  localparam int FLG_RST = 2;
  localparam int FLG_PSH = 3;
  localparam int FLG_ACK = 4;
  localparam int FLG_URG = 5;
  localparam logic [15:0] LOW_PORT_LIM = 16'h0400;
  localparam logic [16:0] MAX_IP_LEN = 17'h0_ffff;
  localparam logic [16:0] TCP_HDR_MIN = 17'h0_0014;
  localparam logic [12:0] TINY_OFS = 13'h0001;
endpackage : dapf_pkg
`default_nettype wire

// file: verilog/dapf_classify.sv
/*
  Combinational signature matcher: one match bit per attack signature.
  Assumes the header parser presents decoded fields for one packet.
*/
`default_nettype none
module dapf_classify (
  input wire logic is_ip,
  input wire logic is_tcp,
  input wire logic is_udp,
  input wire logic is_echo,
  input wire logic [31:0] src_ip,
  input wire logic [31:0] dst_ip,
  input wire logic [15:0] src_port,
  input wire logic [15:0] dst_port,
  input wire logic [31:0] tcp_seq,
  input wire logic [5:0] tcp_flags,
  input wire logic [15:0] ip_len,
  input wire logic [3:0] ip_ihl,
  input wire logic [12:0] frag_off,
  input wire logic more_frag,
  output logic [dapf_pkg::NUM_SIG-1:0] match
);
  import dapf_pkg::*;
  logic [16:0] end_byte;
  logic [16:0] hdr_end;
  logic seq0;
  assign end_byte = {1'b0, frag_off, 3'b000} + {1'b0, ip_len};
  assign hdr_end = {11'h000, ip_ihl, 2'b00} + TCP_HDR_MIN;
  assign seq0 = (tcp_seq == 32'h0000_0000);
  always_comb begin
    match = '0;
    match[SIG_SELF_IP] = is_ip && (src_ip == dst_ip);
    match[SIG_EQ_PORT] = (is_tcp || is_udp) && (src_port == dst_port);
    match[SIG_NULL] = is_tcp && seq0 && (tcp_flags == 6'h00);
    match[SIG_ALLFLG] = is_tcp && seq0 && tcp_flags[FLG_URG]
                        && tcp_flags[FLG_PSH] && tcp_flags[FLG_FIN];
    match[SIG_SYNFIN] = is_tcp && tcp_flags[FLG_SYN] && tcp_flags[FLG_FIN];
    match[SIG_LOWSYN] = is_tcp && tcp_flags[FLG_SYN] && (src_port < LOW_PORT_LIM);
    // Offset plus length beyond the IP maximum can only come from fragments
    match[SIG_OVPING] = is_ip && is_echo && (end_byte > MAX_IP_LEN);
    // Offset of one overlays the header; a short first fragment splits it
    match[SIG_TINY] = is_ip && is_tcp && ((frag_off == TINY_OFS)
                      || (frag_off == 13'h0000 && more_frag
                          && ({1'b0, ip_len} < hdr_end)));
  end
endmodule // dapf_classify
`default_nettype wire

// file: verilog/dapf_filter.sv
/*
  Ingress denial-of-service filter: classifies each parsed packet,
  drops matches of enabled signatures, forwards the rest in order,
  reports detections and holds APB control and status registers.
  Assumes the parser and forwarding engine run on pclk.
*/
`default_nettype none
module dapf_filter #(
  parameter int DW = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dapf_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire logic [DW-1:0] hdr_desc,
  input wire logic is_ip,
  input wire logic is_tcp,
  input wire logic is_udp,
  input wire logic is_echo,
  input wire logic [31:0] src_ip,
  input wire logic [31:0] dst_ip,
  input wire logic [15:0] src_port,
  input wire logic [15:0] dst_port,
  input wire logic [31:0] tcp_seq,
  input wire logic [5:0] tcp_flags,
  input wire logic [15:0] ip_len,
  input wire logic [3:0] ip_ihl,
  input wire logic [12:0] frag_off,
  input wire logic more_frag,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DW-1:0] out_desc,
  output logic det_valid,
  output logic [dapf_pkg::SIG_W-1:0] det_sig,
  output logic trap_valid,
  output logic irq
);
  import dapf_pkg::*;

  generate
    if (DW < 1) begin : g_bad_dw
      $error("dapf_filter: DW must be at least 1");
    end
  endgenerate

  logic [CTRL_W-1:0] ctrl_r;
  logic [NUM_SIG-1:0] sig_en_r;
  logic [NUM_SIG-1:0] mask_r;
  logic [NUM_SIG-1:0] status_r;
  logic [NUM_SIG-1:0] status_nxt;
  logic [NUM_SIG-1:0] mask_nxt;
  logic [CNT_W-1:0] drops_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic hdr_ready_r;
  logic out_valid_r;
  logic out_valid_nxt;
  logic [DW-1:0] out_desc_r;
  logic det_valid_r;
  logic [SIG_W-1:0] det_sig_r;
  logic [SIG_W-1:0] det_sig_nxt;
  logic trap_valid_r;
  logic irq_r;
  logic [NUM_SIG-1:0] match;
  logic [NUM_SIG-1:0] sig_on;
  logic [NUM_SIG-1:0] hit;
  logic take;
  logic drop;
  logic acc;
  logic wr_fire;
  logic mapped;

  dapf_classify u_classify (
    .is_ip(is_ip),
    .is_tcp(is_tcp),
    .is_udp(is_udp),
    .is_echo(is_echo),
    .src_ip(src_ip),
    .dst_ip(dst_ip),
    .src_port(src_port),
    .dst_port(dst_port),
    .tcp_seq(tcp_seq),
    .tcp_flags(tcp_flags),
    .ip_len(ip_len),
    .ip_ihl(ip_ihl),
    .frag_off(frag_off),
    .more_frag(more_frag),
    .match(match)
  );

  // Filtering decision
  assign sig_on = sig_en_r | {NUM_SIG{ctrl_r[CTRL_ALL]}};
  assign hit = match & sig_on & {NUM_SIG{ctrl_r[CTRL_GLB]}};
  assign drop = |hit;
  assign take = hdr_valid && hdr_ready_r;

  // Lowest set bit names the reported signature
  always_comb begin
    det_sig_nxt = '0;
    for (int i = NUM_SIG - 1; i >= 0; i--) begin
      if (hit[i]) begin
        det_sig_nxt = i[SIG_W-1:0];
      end
    end
  end

  // One-entry output stage; ready is registered, so passes alternate
  // with drain cycles that no drop can fill; drops leave ready high and can follow back to back
  assign out_valid_nxt = (out_valid_r && !out_ready) || (take && !drop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_r <= 1'b0;
      hdr_ready_r <= 1'b0;
    end else begin
      out_valid_r <= out_valid_nxt;
      hdr_ready_r <= !out_valid_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_desc_r <= '0;
    end else if (take && !drop) begin
      out_desc_r <= hdr_desc;
    end
  end

  // Detection and trap pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_valid_r <= 1'b0;
      det_sig_r <= '0;
      trap_valid_r <= 1'b0;
    end else begin
      det_valid_r <= take && drop;
      det_sig_r <= det_sig_nxt;
      trap_valid_r <= take && drop && ctrl_r[CTRL_TRAP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drops_r <= '0;
    end else if (take && drop) begin
      drops_r <= drops_r + 32'h0000_0001;
    end
  end

  // APB slave: one wait state, answer in the second access cycle
  assign acc = psel && penable;
  assign wr_fire = acc && pready_r && pwrite;
  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_SIG_EN, OFS_STATUS, OFS_MASK, OFS_DROPS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !mapped;
      prdata_r <= '0;
      if (acc && !pready_r && !pwrite) begin
        case (paddr)
          OFS_CTRL: prdata_r <= {29'h0000_0000, ctrl_r};
          OFS_SIG_EN: prdata_r <= {24'h00_0000, sig_en_r};
          OFS_STATUS: prdata_r <= {24'h00_0000, status_r};
          OFS_MASK: prdata_r <= {24'h00_0000, mask_r};
          OFS_DROPS: prdata_r <= drops_r;
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      sig_en_r <= SIG_EN_RST;
      mask_r <= MASK_RST;
    end else if (wr_fire) begin
      case (paddr)
        OFS_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
        OFS_SIG_EN: sig_en_r <= pwdata[NUM_SIG-1:0];
        OFS_MASK: mask_r <= pwdata[NUM_SIG-1:0];
        default: ;
      endcase
    end
  end

  // Irq must follow a mask write at once, else it lags the register for a cycle
  assign mask_nxt = (wr_fire && paddr == OFS_MASK) ? pwdata[NUM_SIG-1:0] : mask_r;

  // Sticky status; a detection in the clearing cycle survives
  always_comb begin
    status_nxt = status_r;
    if (wr_fire && paddr == OFS_STATUS) begin
      status_nxt = status_nxt & ~pwdata[NUM_SIG-1:0];
    end
    if (take && drop) begin
      status_nxt = status_nxt | hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign hdr_ready = hdr_ready_r;
  assign out_valid = out_valid_r;
  assign out_desc = out_desc_r;
  assign det_valid = det_valid_r;
  assign det_sig = det_sig_r;
  assign trap_valid = trap_valid_r;
  assign irq = irq_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_SELF_IP_DROP: assert property (
    take && ctrl_r[CTRL_GLB] && sig_on[SIG_SELF_IP] && is_ip && src_ip == dst_ip
    |=> det_valid_r && !out_valid_r)
    else $error("self addressed packet not dropped");

  AST_LOW_SYN_DROP: assert property (
    take && ctrl_r[CTRL_GLB] && sig_on[SIG_LOWSYN] && is_tcp
    && tcp_flags[FLG_SYN] && src_port < LOW_PORT_LIM
    |=> det_valid_r)
    else $error("low port syn not detected");

  AST_GLOBAL_OFF: assert property (
    take && !ctrl_r[CTRL_GLB] |=> !det_valid_r && out_valid_r)
    else $error("packet filtered while disabled");

  AST_DISABLED_SIG: assert property (
    take && (match & sig_on) == '0 |=> !det_valid_r)
    else $error("disabled signature acted");

  AST_DROP_NO_FWD: assert property (
    take && drop |=> !out_valid_r ##1 (!out_valid_r || $past(take)))
    else $error("dropped packet forwarded");

  AST_DET_CAUSE: assert property (
    det_valid_r |-> $past(take && drop) && status_r[det_sig_r])
    else $error("detection pulse without drop");

  AST_TRAP_GATE: assert property (
    trap_valid_r == (det_valid_r && $past(ctrl_r[CTRL_TRAP])))
    else $error("trap report mismatch");

  AST_PASS_DATA: assert property (
    take && !drop |=> out_valid_r && out_desc_r == $past(hdr_desc))
    else $error("passed packet altered");

  AST_OUT_HOLD: assert property (
    out_valid_r && !out_ready |=> out_valid_r && $stable(out_desc_r))
    else $error("output dropped under backpressure");

  AST_IRQ_LEVEL: assert property (
    irq_r == |(status_r & mask_r))
    else $error("interrupt level mismatch");

  COV_DROP: cover property (take && drop ##1 trap_valid_r);
  COV_PASS_STALL: cover property (out_valid_r && !out_ready ##1 out_ready);
  COV_MULTI_HIT: cover property (take && $countones(hit) > 1);
  COV_IRQ: cover property (!irq_r ##1 irq_r);

endmodule // dapf_filter
`default_nettype wire

// file: bench/dapf_fwd_model.sv
/*
  Forwarding engine model: takes filtered descriptors, stalling at random.
  Assumes the filter's out_valid/out_ready handshake on pclk.
*/
`default_nettype none
module dapf_fwd_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic out_valid,
  input wire logic [63:0] out_desc,
  output logic out_ready,
  output logic acc_stb,
  output logic [63:0] acc_desc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr_r;
  // Stalls about a quarter of cycles so a held output gets exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 8'h01;
      out_ready <= 1'b0;
      acc_stb <= 1'b0;
      acc_desc <= 64'h0;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      out_ready <= |lfsr_r[1:0];
      acc_stb <= out_valid && out_ready;
      acc_desc <= out_desc;
    end
  end
endmodule // dapf_fwd_model
`default_nettype wire

// file: bench/tb_top.sv
/*
  Bench for the packet filter: APB setup per phase, random packets with corners.
  Assumes dapf_pkg, dapf_filter and dapf_fwd_model compiled before it.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dapf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hdr_valid, hdr_ready, out_valid, out_ready;
  logic is_ip, is_tcp, is_udp, is_echo, more_frag, det_valid, trap_valid, irq, acc_stb, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, src_ip, dst_ip, tcp_seq, rd, seed, drops;
  logic [15:0] src_port, dst_port, ip_len, lp;
  logic [5:0] tcp_flags;
  logic [3:0] ip_ihl;
  logic [12:0] frag_off;
  logic [63:0] hdr_desc, out_desc, acc_desc;
  logic [SIG_W-1:0] det_sig;
  logic [7:0] en, msk, exp_st;
  logic [CTRL_W-1:0] ctl;
  logic [63:0] expq[$];
  int bad_count, total_checks;
  dapf_filter dut (.*);
  dapf_fwd_model fwd (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] hits();
    logic [7:0] m;
    m[0] = is_ip && src_ip == dst_ip;
    m[1] = (is_tcp || is_udp) && src_port == dst_port;
    m[2] = is_tcp && tcp_seq == 0 && tcp_flags == 0;
    m[3] = is_tcp && tcp_seq == 0 && tcp_flags[FLG_URG] && tcp_flags[FLG_PSH] && tcp_flags[FLG_FIN];
    m[4] = is_tcp && tcp_flags[FLG_SYN] && tcp_flags[FLG_FIN];
    m[5] = is_tcp && tcp_flags[FLG_SYN] && src_port < LOW_PORT_LIM;
    m[6] = is_ip && is_echo && {frag_off, 3'h0} + ip_len > MAX_IP_LEN;
    m[7] = is_ip && is_tcp && (frag_off == TINY_OFS || (frag_off == 0 && more_frag && ip_len < ip_ihl * 4 + TCP_HDR_MIN));
    return m;
  endfunction
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, "bus timeout");
    // Idle a cycle so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask
  task automatic send();
    logic [7:0] m;
    int n, s;
    hdr_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (hdr_ready !== 1'b1 && n < 20);
    hdr_valid <= 1'b0;
    chk(n < 20, "take timeout");
    m = ctl[CTRL_GLB] ? hits() & (ctl[CTRL_ALL] ? 8'hff : en) : 8'h00;
    if (m == 0)
      expq.push_back(hdr_desc);
    else
      drops++;
    exp_st |= m;
    s = 0;
    for (int i = 7; i >= 0; i--)
      if (m[i]) s = i;
    @(posedge pclk);
    chk(det_valid === (m != 0) && (m == 0 || det_sig === s[SIG_W-1:0]), "det");
    chk(trap_valid === (m != 0 && ctl[CTRL_TRAP]), "trap");
  endtask
  always @(posedge pclk) begin
    if (acc_stb === 1'b1) begin
      chk(expq.size() > 0 && acc_desc === expq[0], "fwd");
      if (expq.size() > 0)
        void'(expq.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #1_000_000;
    chk(1'b0, "watchdog");
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, hdr_valid, is_ip, is_tcp, is_udp, is_echo, more_frag} = '0;
    {paddr, pwdata, hdr_desc, src_ip, dst_ip, src_port, dst_port, tcp_seq, tcp_flags, ip_len, ip_ihl, frag_off} = '0;
    {bad_count, total_checks, drops, ctl, en} = '0;
    seed = 32'h0000_005d;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ADDR_W'(i * 4), 32'h0);
      chk(rd === 32'h0 && err === (i == 5), "reset read");
    end
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk(err === 1'b1, "unmapped write");
    for (int p = 0; p < 5; p++) begin
      seed = xs(seed);
      ctl = p == 1 ? 3'h1 : p == 2 ? 3'h5 : p == 3 ? 3'h2 : 3'h3;
      en = p == 0 ? 8'hff : p == 2 ? 8'h00 : seed[7:0];
      msk = seed[15:8];
      apb(1'b1, OFS_CTRL, {29'h0, ctl});
      apb(1'b1, OFS_SIG_EN, {24'h0, en});
      apb(1'b1, OFS_MASK, {24'h0, msk});
      apb(1'b1, OFS_STATUS, 32'h0000_00ff);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd === 32'h0 && irq === 1'b0, "clear");
      exp_st = 8'h00;
      for (int k = 0; k < 60; k++) begin
        seed = xs(seed);
        // Source port straddles the 1023/1024 edge half the time
        lp = seed[1] ? 16'h03ff + 16'(seed[2]) : seed[31:16];
        is_ip <= seed[0] | seed[3];
        is_tcp <= seed[4];
        is_udp <= seed[5] & ~seed[4];
        is_echo <= seed[6];
        more_frag <= seed[7];
        tcp_flags <= seed[8] ? 6'h00 : seed[14:9];
        ip_ihl <= 4'h5 + 4'(seed[16:15]);
        frag_off <= seed[17] ? 13'(seed[19:18]) : 13'h1fff;
        src_port <= lp;
        dst_port <= seed[20] ? lp : ~lp;
        seed = xs(seed);
        src_ip <= seed;
        dst_ip <= seed[0] ? seed : ~seed;
        tcp_seq <= seed[1] ? 32'h0 : seed;
        ip_len <= seed[2] ? 16'(seed[8:3]) : seed[31:16];
        hdr_desc <= {seed, xs(seed)};
        send();
      end
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd === {24'h0, exp_st} && irq === |(exp_st & msk), "status");
      apb(1'b0, OFS_DROPS, 32'h0);
      chk(rd === drops, "drops");
    end
    // Let the last passed packet drain through a stalling receiver
    repeat (10) @(posedge pclk);
    chk(expq.size() == 0, "lost");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
